//--- verilog/cfd_config_decode.sv
// Function
// - config byte 3 high bit 2 selects low power timer oscillator
// - unimplemented configuration bit positions always read as zero
// - every configuration bit starts at its unprogrammed default value
// - debug bit 1 frees debug pins as gpio, 0 dedicates them to debug
// - extended instruction bit enables extension and indexed addressing
// - single supply bit allows programming entry without high voltage
// - stack fault reset bit makes stack full or underflow reset device
// - data read protect blocks all external eeprom reads and writes
// - data write protect blocks cpu and external eeprom writes
// - cpu may always read data eeprom in normal operation
// - config write protect blocks writes to configuration registers
// - config write protect is read only to cpu, programmer may change it
// - eight user id bytes up to 200007h, table and programmer access
// - user id bytes stay readable under code protection
`timescale 1ns/1ns
`default_nettype none
module cfd_config_decode
    import cfd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire cfd_pkg::cfd_req_s cpu_req,
    output cfd_pkg::cfd_rsp_s cpu_rsp,
    input wire logic prog_mode,
    input wire cfd_pkg::cfd_req_s prog_req,
    output cfd_pkg::cfd_rsp_s prog_rsp,
    output cfd_pkg::cfd_dec_s cfg,
    input wire logic stack_fault,
    output logic stack_reset_req,
    input wire logic lv_entry_req,
    output logic lv_entry_grant,
    input wire logic ee_cpu_rd_req,
    input wire logic ee_cpu_wr_req,
    input wire logic ee_ext_rd_req,
    input wire logic ee_ext_wr_req,
    output logic ee_cpu_rd_grant,
    output logic ee_cpu_wr_grant,
    output logic ee_ext_rd_grant,
    output logic ee_ext_wr_grant
);
    import cfd_pkg::*;

    logic [7:0] cb3h_q, cb3h_d, cb4l_q, cb4l_d, prot_q, prot_d;
    cfd_rsp_s cpu_rsp_q, cpu_rsp_d, prog_rsp_q, prog_rsp_d;
    cfd_dec_s dec_q, dec_d;
    logic stk_q, stk_d, lve_q, lve_d;
    logic [3:0] ee_q, ee_d;
    logic id_we;
    logic [ID_AW-1:0] id_waddr;
    logic [7:0] id_wdata, id_rd_cpu, id_rd_prog;

    ////////////////////////////////////////////////////////////////////////
    cfd_id_store u_ids (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(id_we),
        .waddr(id_waddr),
        .wdata(id_wdata),
        .raddr_a(cpu_req.addr[ID_AW-1:0]),
        .raddr_b(prog_req.addr[ID_AW-1:0]),
        .rdata_a(id_rd_cpu),
        .rdata_b(id_rd_prog)
    );

    ////////////////////////////////////////////////////////////////////////
    // register access from cpu table ops and from the programmer
    always_comb
    begin
        cb3h_d = cb3h_q;
        cb4l_d = cb4l_q;
        prot_d = prot_q;
        cpu_rsp_d = '0;
        prog_rsp_d = '0;
        id_we = 1'b0;
        id_waddr = '0;
        id_wdata = '0;
        // cpu side: refused while the programmer owns the device
        if (cpu_req.req)
        begin
            cpu_rsp_d.ack = 1'b1;
            if (prog_mode)
                cpu_rsp_d.err = 1'b1;
            else if (cpu_req.addr == CB3H_ADDR)
            begin
                cpu_rsp_d.rdata = cb3h_q & CB3H_MASK;
                if (cpu_req.wr && prot_q[CWP_BIT])
                    cpu_rsp_d.err = 1'b1;
                else if (cpu_req.wr)
                    cb3h_d = cpu_req.wdata & CB3H_MASK;
            end
            else if (cpu_req.addr == CB4L_ADDR)
            begin
                cpu_rsp_d.rdata = cb4l_q & CB4L_MASK;
                if (cpu_req.wr && prot_q[CWP_BIT])
                    cpu_rsp_d.err = 1'b1;
                else if (cpu_req.wr)
                    cb4l_d = cpu_req.wdata & CB4L_MASK;
            end
            else if (cpu_req.addr == PROT_ADDR)
            begin
                cpu_rsp_d.rdata = prot_q;
                cpu_rsp_d.err = cpu_req.wr;
            end
            else if (cfd_is_id(cpu_req.addr))
            begin
                cpu_rsp_d.rdata = id_rd_cpu;
                if (cpu_req.wr)
                begin
                    id_we = 1'b1;
                    id_waddr = cpu_req.addr[ID_AW-1:0];
                    id_wdata = cpu_req.wdata;
                end
            end
            else
                cpu_rsp_d.err = 1'b1;
        end
        // programmer side: only in programming mode
        if (prog_req.req)
        begin
            prog_rsp_d.ack = 1'b1;
            if (!prog_mode)
                prog_rsp_d.err = 1'b1;
            else if (prog_req.addr == CB3H_ADDR)
            begin
                prog_rsp_d.rdata = cb3h_q & CB3H_MASK;
                if (prog_req.wr && prot_q[CWP_BIT])
                    prog_rsp_d.err = 1'b1;
                else if (prog_req.wr)
                    cb3h_d = prog_req.wdata & CB3H_MASK;
            end
            else if (prog_req.addr == CB4L_ADDR)
            begin
                prog_rsp_d.rdata = cb4l_q & CB4L_MASK;
                if (prog_req.wr && prot_q[CWP_BIT])
                    prog_rsp_d.err = 1'b1;
                else if (prog_req.wr)
                    cb4l_d = prog_req.wdata & CB4L_MASK;
            end
            else if (prog_req.addr == PROT_ADDR)
            begin
                prog_rsp_d.rdata = prot_q;
                if (prog_req.wr)
                    prot_d = prog_req.wdata & PROT_MASK;
            end
            else if (cfd_is_id(prog_req.addr))
            begin
                prog_rsp_d.rdata = id_rd_prog;
                if (prog_req.wr)
                begin
                    id_we = 1'b1;
                    id_waddr = prog_req.addr[ID_AW-1:0];
                    id_wdata = prog_req.wdata;
                end
            end
            else
                prog_rsp_d.err = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cb3h_q <= CB3H_DEFAULT;
            cb4l_q <= CB4L_DEFAULT;
            prot_q <= PROT_DEFAULT;
            cpu_rsp_q <= '0;
            prog_rsp_q <= '0;
        end
        else
        begin
            cb3h_q <= cb3h_d;
            cb4l_q <= cb4l_d;
            prot_q <= prot_d;
            cpu_rsp_q <= cpu_rsp_d;
            prog_rsp_q <= prog_rsp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded settings and the requests they steer
    always_comb
    begin
        dec_d = cfd_decode(cb3h_d, cb4l_d);
        stk_d = stack_fault && dec_q.stack_fault_reset_enable;
        lve_d = lv_entry_req
            && dec_q.single_supply_program_enable;
        ee_d[0] = ee_cpu_rd_req;
        ee_d[1] = ee_cpu_wr_req && !prot_q[DWP_BIT];
        ee_d[2] = ee_ext_rd_req && !prot_q[DRP_BIT];
        ee_d[3] = ee_ext_wr_req && !prot_q[DRP_BIT]
            && !prot_q[DWP_BIT];
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dec_q <= DEC_RESET;
            stk_q <= 1'b0;
            lve_q <= 1'b0;
            ee_q <= '0;
        end
        else
        begin
            dec_q <= dec_d;
            stk_q <= stk_d;
            lve_q <= lve_d;
            ee_q <= ee_d;
        end
    end

    assign cpu_rsp = cpu_rsp_q;
    assign prog_rsp = prog_rsp_q;
    assign cfg = dec_q;
    assign stack_reset_req = stk_q;
    assign lv_entry_grant = lve_q;
    assign ee_cpu_rd_grant = ee_q[0];
    assign ee_cpu_wr_grant = ee_q[1];
    assign ee_ext_rd_grant = ee_q[2];
    assign ee_ext_wr_grant = ee_q[3];

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    AST_PIN_MODE: assert property (
        cfg.reset_pin_enable == cb3h_q[RPE_BIT]
        && cfg.shared_reset_input_en == !cb3h_q[RPE_BIT])
        else $error("reset pin mode does not follow its bit");
    AST_LPT_OSC: assert property (
        cfg.low_power_timer_osc_enable == cb3h_q[LPT_BIT])
        else $error("timer oscillator mode does not follow bit 2");
    AST_UNIMPL_ZERO: assert property (
        cpu_rsp.ack && $past(cpu_req.addr) == CB4L_ADDR
        |-> (cpu_rsp.rdata & ~CB4L_MASK) == 8'h00)
        else $error("unimplemented config bits read nonzero");
    AST_DEFAULTS: assert property (
        $rose(arst_n) |-> cb3h_q == CB3H_DEFAULT && cb4l_q == CB4L_DEFAULT)
        else $error("config bytes not at defaults after reset");
    AST_DEBUG_PINS: assert property (
        cfg.debug_pins_gpio == cb4l_q[DBG_BIT]
        && cfg.debug_pins_dedicated == !cb4l_q[DBG_BIT])
        else $error("debug pin use does not follow debug bit");
    AST_EXT_INSTR: assert property (
        cfg.extended_instruction_enable == cb4l_q[XIN_BIT])
        else $error("extended instruction enable mismatch");
    AST_LV_ENTRY: assert property (
        lv_entry_req |=> lv_entry_grant == $past(cb4l_q[SSP_BIT]))
        else $error("low voltage entry grant wrong");
    AST_STACK_RESET: assert property (
        stack_fault |=> stack_reset_req == $past(cb4l_q[STK_BIT]))
        else $error("stack fault reset request wrong");
    AST_EE_EXT_RD: assert property (
        ee_ext_rd_req && prot_q[DRP_BIT] |=> !ee_ext_rd_grant)
        else $error("external eeprom read granted under protection");
    AST_EE_CPU_WR: assert property (
        ee_cpu_wr_req && prot_q[DWP_BIT] |=> !ee_cpu_wr_grant)
        else $error("cpu eeprom write granted under protection");
    AST_EE_CPU_RD: assert property (
        ee_cpu_rd_req |=> ee_cpu_rd_grant)
        else $error("cpu eeprom read refused");
    AST_CFG_WP: assert property (
        cpu_req.req && cpu_req.wr && cpu_req.addr == CB3H_ADDR
        && prot_q[CWP_BIT] |=> $stable(cb3h_q) && cpu_rsp.err)
        else $error("config write passed under write protection");
    AST_PROT_RO: assert property (
        !prog_req.req |=> $stable(prot_q))
        else $error("protection byte changed without programmer");
    AST_ID_READ: assert property (
        cpu_req.req && !prog_mode && cfd_is_id(cpu_req.addr)
        |=> cpu_rsp.ack && !cpu_rsp.err)
        else $error("user id access refused");

    COV_CFG_WRITE: cover property (
        cpu_req.req && cpu_req.wr && cpu_req.addr == CB4L_ADDR ##1 !cpu_rsp.err);
    COV_PROT_SET: cover property (
        prog_req.req && prog_req.wr && prog_req.addr == PROT_ADDR);
    COV_ID_PROTECTED: cover property (
        prot_q[CWP_BIT] && cpu_req.req && cfd_is_id(cpu_req.addr));
    COV_STACK: cover property (stack_reset_req);
endmodule : cfd_config_decode
`default_nettype wire

//--- shared/cfd_pkg.sv
package cfd_pkg;

    localparam int ADDR_W = 22;
    localparam int ID_COUNT = 8;
    localparam int ID_AW = 3;

    ////////////////////////////////////////////////////////////////////////
    // address map
    localparam logic [ADDR_W-1:0] CB3H_ADDR = 22'h300005;
    localparam logic [ADDR_W-1:0] CB4L_ADDR = 22'h300006;
    localparam logic [ADDR_W-1:0] PROT_ADDR = 22'h30000b;
    localparam logic [ADDR_W-1:0] ID_BASE = 22'h200000;

    ////////////////////////////////////////////////////////////////////////
    // config_byte_3_high fields
    localparam int RPE_BIT = 7;
    localparam int LPT_BIT = 2;
    localparam int PBAD_BIT = 1;
    localparam int CCP2_BIT = 0;
    localparam logic [7:0] CB3H_MASK = 8'h87;
    localparam logic [7:0] CB3H_DEFAULT = 8'h83;

    // config_byte_4_low fields
    localparam int DBG_BIT = 7;
    localparam int XIN_BIT = 6;
    localparam int SSP_BIT = 2;
    localparam int STK_BIT = 0;
    localparam logic [7:0] CB4L_MASK = 8'hc5;
    localparam logic [7:0] CB4L_DEFAULT = 8'h85;

    // protection byte fields, active high
    localparam int DRP_BIT = 0;
    localparam int DWP_BIT = 1;
    localparam int CWP_BIT = 2;
    localparam logic [7:0] PROT_MASK = 8'h07;
    localparam logic [7:0] PROT_DEFAULT = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic req;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } cfd_req_s;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
    } cfd_rsp_s;

    typedef struct packed {
        logic reset_pin_enable;
        logic shared_reset_input_en;
        logic low_power_timer_osc_enable;
        logic debug_pins_dedicated;
        logic debug_pins_gpio;
        logic extended_instruction_enable;
        logic single_supply_program_enable;
        logic stack_fault_reset_enable;
    } cfd_dec_s;

    function automatic cfd_dec_s cfd_decode(logic [7:0] b3h, logic [7:0] b4l);
        cfd_dec_s d;
        d.reset_pin_enable = b3h[RPE_BIT];
        d.shared_reset_input_en = ~b3h[RPE_BIT];
        d.low_power_timer_osc_enable = b3h[LPT_BIT];
        d.debug_pins_dedicated = ~b4l[DBG_BIT];
        d.debug_pins_gpio = b4l[DBG_BIT];
        d.extended_instruction_enable = b4l[XIN_BIT];
        d.single_supply_program_enable = b4l[SSP_BIT];
        d.stack_fault_reset_enable = b4l[STK_BIT];
        return d;
    endfunction : cfd_decode

    localparam cfd_dec_s DEC_RESET = cfd_decode(CB3H_DEFAULT, CB4L_DEFAULT);

    function automatic logic cfd_is_id(logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:ID_AW] == ID_BASE[ADDR_W-1:ID_AW];
    endfunction : cfd_is_id

endpackage : cfd_pkg

//--- verilog/cfd_id_store.sv
`timescale 1ns/1ns
`default_nettype none
module cfd_id_store
    import cfd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic we,
    input wire logic [ID_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [ID_AW-1:0] raddr_a,
    input wire logic [ID_AW-1:0] raddr_b,
    output logic [7:0] rdata_a,
    output logic [7:0] rdata_b
);
    logic [7:0] mem_q [ID_COUNT];
    logic [7:0] mem_d [ID_COUNT];

    // erased user id bytes read all ones
    genvar i;
    generate
        for (i = 0; i < ID_COUNT; i++)
        begin : g_loc
            always_comb
            begin
                mem_d[i] = mem_q[i];
                if (we && (waddr == ID_AW'(i)))
                    mem_d[i] = wdata;
            end
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    mem_q[i] <= 8'hff;
                else
                    mem_q[i] <= mem_d[i];
            end
        end
    endgenerate

    assign rdata_a = mem_q[raddr_a];
    assign rdata_b = mem_q[raddr_b];
endmodule : cfd_id_store
`default_nettype wire

//--- testbench/cfd_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
module cfd_prog_model
    import cfd_pkg::*;
(
    input wire logic ref_clk,
    output cfd_pkg::cfd_req_s req,
    input wire cfd_pkg::cfd_rsp_s rsp
);
    initial req = '{1'b0, 1'b0, '0, 8'h00};

    ////////////////////////////////////////////////////////////////////////
    // one byte per request, optional idle gap before it
    // protection byte writes reach the device only from the programmer side, id writes from either side
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
        input logic [7:0] wdata, input int gap, output logic [7:0] rdata,
        output logic err);
        int n;
        n = 0;
        repeat (gap) @(negedge ref_clk);
        @(negedge ref_clk);
        req = '{1'b1, wr, addr, wdata};
        @(negedge ref_clk);
        // idle fields inverted so stale values never look valid
        req = '{1'b0, ~wr, ~addr, ~wdata};
        while (rsp.ack !== 1'b1 && n < 3)
        begin
            @(negedge ref_clk);
            n++;
        end
        rdata = rsp.rdata;
        err = (rsp.ack === 1'b1) ? rsp.err : 1'bx;
    endtask : xfer
endmodule : cfd_prog_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import cfd_pkg::*;
;
    typedef struct packed {
        logic mode;
        logic who;
        logic wr;
        logic [21:0] addr;
        logic [7:0] wd;
        logic [7:0] rd;
        logic err;
    } cfd_row_s;

    localparam cfd_row_s ROWS [21] = '{
        '{1'b0, 1'b0, 1'b0, CB3H_ADDR, 8'h00, 8'h83, 1'b0},
        '{1'b0, 1'b0, 1'b0, CB4L_ADDR, 8'h00, 8'h85, 1'b0},
        '{1'b0, 1'b0, 1'b1, CB3H_ADDR, 8'hff, 8'h83, 1'b0},
        '{1'b0, 1'b0, 1'b0, CB3H_ADDR, 8'h00, 8'h87, 1'b0},
        '{1'b0, 1'b0, 1'b1, CB4L_ADDR, 8'h00, 8'h85, 1'b0},
        '{1'b0, 1'b0, 1'b0, CB4L_ADDR, 8'h00, 8'h00, 1'b0},
        '{1'b0, 1'b0, 1'b1, 22'h200007, 8'ha5, 8'hff, 1'b0},
        '{1'b0, 1'b0, 1'b0, 22'h200007, 8'h00, 8'ha5, 1'b0},
        '{1'b0, 1'b0, 1'b0, 22'h200008, 8'h00, 8'h00, 1'b1},
        '{1'b0, 1'b0, 1'b1, PROT_ADDR, 8'h07, 8'h00, 1'b1},
        '{1'b0, 1'b0, 1'b0, PROT_ADDR, 8'h00, 8'h00, 1'b0},
        '{1'b1, 1'b1, 1'b1, PROT_ADDR, 8'h04, 8'h00, 1'b0},
        '{1'b1, 1'b1, 1'b0, PROT_ADDR, 8'h00, 8'h04, 1'b0},
        '{1'b1, 1'b1, 1'b1, CB3H_ADDR, 8'h00, 8'h00, 1'b1},
        '{1'b1, 1'b1, 1'b0, CB3H_ADDR, 8'h00, 8'h87, 1'b0},
        '{1'b1, 1'b0, 1'b0, CB3H_ADDR, 8'h00, 8'h00, 1'b1},
        '{1'b0, 1'b1, 1'b0, CB3H_ADDR, 8'h00, 8'h00, 1'b1},
        '{1'b1, 1'b1, 1'b0, 22'h200007, 8'h00, 8'ha5, 1'b0},
        '{1'b0, 1'b0, 1'b1, CB4L_ADDR, 8'hff, 8'h00, 1'b1},
        '{1'b0, 1'b0, 1'b1, CB3H_ADDR, 8'h00, 8'h00, 1'b1},
        '{1'b0, 1'b0, 1'b1, 22'h200000, 8'h3c, 8'hff, 1'b0}
    };

    logic ref_clk;
    logic arst_n;
    logic prog_mode;
    logic stack_fault;
    logic lv_entry_req;
    logic [3:0] ee_req;
    cfd_req_s cpu_req;
    cfd_req_s prog_req;
    cfd_rsp_s cpu_rsp;
    cfd_rsp_s prog_rsp;
    cfd_dec_s cfg;
    logic stack_reset_req;
    logic lv_entry_grant;
    wire [3:0] ee_gnt;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    cfd_config_decode i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .prog_mode(prog_mode),
        .prog_req(prog_req), .prog_rsp(prog_rsp), .cfg(cfg),
        .stack_fault(stack_fault), .stack_reset_req(stack_reset_req),
        .lv_entry_req(lv_entry_req), .lv_entry_grant(lv_entry_grant),
        .ee_cpu_rd_req(ee_req[3]), .ee_cpu_wr_req(ee_req[2]),
        .ee_ext_rd_req(ee_req[1]), .ee_ext_wr_req(ee_req[0]),
        .ee_cpu_rd_grant(ee_gnt[3]), .ee_cpu_wr_grant(ee_gnt[2]),
        .ee_ext_rd_grant(ee_gnt[1]), .ee_ext_wr_grant(ee_gnt[0]));
    cfd_prog_model i_cpu (.ref_clk(ref_clk), .req(cpu_req), .rsp(cpu_rsp));
    cfd_prog_model i_prog (.ref_clk(ref_clk), .req(prog_req),
        .rsp(prog_rsp));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic run_row(input cfd_row_s r, input int gap);
        logic [7:0] rd;
        logic er;
        @(negedge ref_clk);
        prog_mode = r.mode;
        if (r.who)
            i_prog.xfer(r.wr, r.addr, r.wd, gap, rd, er);
        else
            i_cpu.xfer(r.wr, r.addr, r.wd, gap, rd, er);
        chk({7'h00, er}, {7'h00, r.err});
        if (r.err == 1'b0)
            chk(rd, r.rd);
    endtask : run_row

    // all requests for one cycle, grants one cycle later
    task automatic probe(input logic [3:0] ee_exp, input logic [1:0] ev_exp);
        @(negedge ref_clk);
        ee_req = 4'hf;
        stack_fault = 1'b1;
        lv_entry_req = 1'b1;
        @(negedge ref_clk);
        ee_req = 4'h0;
        stack_fault = 1'b0;
        lv_entry_req = 1'b0;
        chk({4'h0, ee_gnt}, {4'h0, ee_exp});
        chk({6'h00, stack_reset_req, lv_entry_grant},
            {6'h00, ev_exp});
    endtask : probe

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            close_out();
        end
    end

    initial
    begin
        arst_n = 1'b0;
        prog_mode = 1'b0;
        stack_fault = 1'b0;
        lv_entry_req = 1'b0;
        ee_req = 4'h0;
        repeat (20) @(negedge ref_clk);
        arst_n = 1'b1;
        chk(cfg, 8'h8b);
        for (int i = 0; i < 21; i++)
            run_row(ROWS[i], i % 2);
        chk(cfg, 8'hb0);
        for (int p = 0; p < 4; p++)
        begin
            run_row('{1'b1, 1'b1, 1'b1, PROT_ADDR, 8'(p),
                (p == 0) ? 8'h04 : 8'(p - 1), 1'b0}, 0);
            probe({1'b1, ~p[1], ~p[0], ~(p[0] | p[1])},
                2'b00);
        end
        run_row('{1'b1, 1'b1, 1'b1, CB4L_ADDR, 8'h45, 8'h00, 1'b0},
            0);
        chk(cfg, 8'hb7);
        probe(4'h8, 2'b11);
        run_row('{1'b1, 1'b1, 1'b1, CB3H_ADDR, 8'h04, 8'h87, 1'b0},
            1);
        chk(cfg, 8'h77);
        @(negedge ref_clk);
        arst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(cfg, 8'h8b);
        chk(cpu_rsp.rdata, 8'h00);
        chk({6'h00, cpu_rsp.ack, cpu_rsp.err}, 8'h00);
        arst_n = 1'b1;
        run_row('{1'b0, 1'b0, 1'b0, CB3H_ADDR, 8'h00, 8'h83, 1'b0},
            0);
        run_row('{1'b0, 1'b0, 1'b0, 22'h200007, 8'h00, 8'hff, 1'b0},
            0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
